/* File: verilog/vga_attr_regs.svh */
// Port addresses, indices, field positions and reset values
// Assumes inclusion by bare name from the design files
`ifndef VGA_ATTR_REGS_SVH
`define VGA_ATTR_REGS_SVH

// ----------------------------------------------------------
// Host port addresses
// ----------------------------------------------------------
`define PORT_ATTR_INDEX   16'h03C0
`define PORT_ATTR_READ    16'h03C1
`define PORT_PIX_MASK     16'h03C6
`define PORT_RD_POINTER   16'h03C7
`define PORT_WR_POINTER   16'h03C8
`define PORT_PAL_DATA     16'h03C9
`define PORT_STAT1_MONO   16'h03BA
`define PORT_STAT1_COLOUR 16'h03DA

// ----------------------------------------------------------
// Attribute register indices
// ----------------------------------------------------------
`define IDX_MODE_CONTROL  5'h10
`define IDX_BORDER        5'h11
`define IDX_PLANE_ENABLE  5'h12
`define IDX_HPAN          5'h13
`define IDX_PIXEL_PAD     5'h14

// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define MODE_GRAPHICS     0
`define MODE_MONO         1
`define MODE_LINE_GFX     2
`define MODE_BLINK        3
`define MODE_TOP_PAN      5
`define MODE_COLOUR256    6
`define MODE_PAD_SELECT   7
`define INDEX_VIDEO_EN    5
`define STAT1_INACTIVE    0
`define STAT1_VSYNC       3

// ----------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------
`define ATTR_RESET        8'h00
`define MASK_RESET        8'hFF
`define INDEX_RESET       5'h00
`define ACCESS_READ       2'h3
`define ACCESS_WRITE      2'h0

`endif

/* File: verilog/vga_attr_pkg.sv */
// Types shared by the attribute and palette register bank
// Assumes nothing of its surroundings
package vga_attr_pkg;

  typedef enum logic {
    ATTR_IDX  = 1'b0,
    ATTR_DATA = 1'b1
  } attr_phase_t;

  typedef enum logic [1:0] {
    PH_RED   = 2'b00,
    PH_GREEN = 2'b01,
    PH_BLUE  = 2'b10
  } colour_phase_t;

endpackage

/* File: verilog/vga_pixel_mux.sv */
// Pixel padding and read mask ahead of the palette lookup
// Assumes one attribute colour byte per clock
`include "vga_attr_regs.svh"

module vga_pixel_mux
  import vga_attr_pkg::*;
(
  input  logic       sys_clk_i,
  input  logic       rst_i,
  input  logic [7:0] colour_i,
  input  logic       pad_select_i,
  input  logic       colour256_i,
  input  logic [3:0] pad_i,
  input  logic [7:0] mask_i,
  output logic [7:0] pix_o
);

  logic [7:0] pix;
  logic [7:0] next_pix;
  logic [7:0] padded;

  // ----------------------------------------------------------
  // Padding and mask
  // ----------------------------------------------------------
  always_comb begin
    padded = colour_i;
    if (!colour256_i) begin
      padded[7:6] = pad_i[3:2];
      if (pad_select_i) begin
        padded[5:4] = pad_i[1:0];
      end
    end
    next_pix = padded & mask_i;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pix <= `ATTR_RESET;
    end else begin
      pix <= next_pix;
    end
  end

  assign pix_o = pix;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_PAD_HIGH: assert property (
    !colour256_i |=> pix_o[7:6] == ($past(pad_i[3:2]) & $past(mask_i[7:6])))
    else $error("high pixel bits not taken from padding");

  AST_PAD_MID: assert property (
    (pad_select_i && !colour256_i)
    |=> pix_o[5:4] == ($past(pad_i[1:0]) & $past(mask_i[5:4])))
    else $error("middle pixel bits not taken from padding");

  AST_MASK: assert property (
    ##1 (pix_o & ~$past(mask_i)) == 8'h00)
    else $error("masked pixel bit not forced to zero");

endmodule

/* File: verilog/vga_palette_ram.sv */
// Colour palette with auto-indexed host port and pixel lookup
// Assumes one host access per strobe, three bytes per entry
`include "vga_attr_regs.svh"

module vga_palette_ram
  import vga_attr_pkg::*;
#(
  parameter int IDX_W  = 8,
  parameter int COMP_W = 6
) (
  input  logic              sys_clk_i,
  input  logic              rst_i,
  input  logic              data_wr_i,
  input  logic              data_rd_i,
  input  logic [7:0]        wdata_i,
  input  logic              rd_load_i,
  input  logic              wr_load_i,
  input  logic [IDX_W-1:0]  pixel_addr_i,
  output logic [7:0]        host_byte_o,
  output logic [IDX_W-1:0]  wr_index_o,
  output logic [1:0]        status_o,
  output logic [3*COMP_W-1:0] rgb_o
);

  logic [3*COMP_W-1:0] mem [2**IDX_W];
  logic [IDX_W-1:0]    rd_index, next_rd_index;
  logic [IDX_W-1:0]    wr_index, next_wr_index;
  colour_phase_t       rd_phase, next_rd_phase;
  colour_phase_t       wr_phase, next_wr_phase;
  logic [COMP_W-1:0]   red, next_red, green, next_green;
  logic [1:0]          status, next_status;
  logic [3*COMP_W-1:0] rgb;
  logic [3*COMP_W-1:0] entry;

  // ----------------------------------------------------------
  // Index and phase control
  // ----------------------------------------------------------
  always_comb begin
    next_rd_index = rd_index;
    next_wr_index = wr_index;
    next_rd_phase = rd_phase;
    next_wr_phase = wr_phase;
    next_red      = red;
    next_green    = green;
    next_status   = status;
    if (rd_load_i) begin
      next_rd_index = wdata_i[IDX_W-1:0];
      next_rd_phase = PH_RED;
      next_status   = `ACCESS_READ;
    end else if (data_rd_i) begin
      next_status = `ACCESS_READ;
      unique case (rd_phase)
        PH_RED:   next_rd_phase = PH_GREEN;
        PH_GREEN: next_rd_phase = PH_BLUE;
        default: begin
          next_rd_phase = PH_RED;
          next_rd_index = rd_index + 1'b1;
        end
      endcase
    end
    if (wr_load_i) begin
      next_wr_index = wdata_i[IDX_W-1:0];
      next_wr_phase = PH_RED;
      next_status   = `ACCESS_WRITE;
    end else if (data_wr_i) begin
      next_status = `ACCESS_WRITE;
      unique case (wr_phase)
        PH_RED: begin
          next_red      = wdata_i[COMP_W-1:0];
          next_wr_phase = PH_GREEN;
        end
        PH_GREEN: begin
          next_green    = wdata_i[COMP_W-1:0];
          next_wr_phase = PH_BLUE;
        end
        default: begin
          next_wr_phase = PH_RED;
          next_wr_index = wr_index + 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_index <= '0;
      wr_index <= '0;
      rd_phase <= PH_RED;
      wr_phase <= PH_RED;
      red      <= '0;
      green    <= '0;
      status   <= `ACCESS_WRITE;
    end else begin
      rd_index <= next_rd_index;
      wr_index <= next_wr_index;
      rd_phase <= next_rd_phase;
      wr_phase <= next_wr_phase;
      red      <= next_red;
      green    <= next_green;
      status   <= next_status;
    end
  end

  // ----------------------------------------------------------
  // Storage and lookups
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (data_wr_i && !wr_load_i && wr_phase == PH_BLUE) begin
      mem[wr_index] <= {red, green, wdata_i[COMP_W-1:0]};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rgb <= '0;
    end else begin
      rgb <= mem[pixel_addr_i];
    end
  end

  always_comb begin
    entry       = mem[rd_index];
    host_byte_o = 8'h00;
    unique case (rd_phase)
      PH_RED:   host_byte_o[COMP_W-1:0] = entry[3*COMP_W-1:2*COMP_W];
      PH_GREEN: host_byte_o[COMP_W-1:0] = entry[2*COMP_W-1:COMP_W];
      default:  host_byte_o[COMP_W-1:0] = entry[COMP_W-1:0];
    endcase
  end

  assign wr_index_o = wr_index;
  assign status_o   = status;
  assign rgb_o      = rgb;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_RD_LOAD: assert property (
    rd_load_i |=> rd_index == $past(wdata_i[IDX_W-1:0]) && rd_phase == PH_RED)
    else $error("read pointer not loaded");

  AST_WR_ADVANCE: assert property (
    (data_wr_i && !wr_load_i && wr_phase == PH_BLUE)
    |=> wr_index == $past(wr_index) + 1'b1)
    else $error("write pointer did not advance after third byte");

endmodule

/* File: verilog/vga_attribute_palette_regs.sv */
// Attribute tail registers and palette host ports on byte I/O cycles
// Assumes one-cycle read or write strobes, never both at once
`include "vga_attr_regs.svh"

module vga_attribute_palette_regs
  import vga_attr_pkg::*;
#(
  parameter int IDX_W  = 8,
  parameter int COMP_W = 6
) (
  input  logic                sys_clk_i,
  input  logic                rst_i,
  input  logic [15:0]         io_addr_i,
  input  logic                io_wr_i,
  input  logic                io_rd_i,
  input  logic [7:0]          io_wdata_i,
  input  logic                vsync_i,
  input  logic                display_inactive_i,
  input  logic [7:0]          attr_colour_i,
  output logic [7:0]          io_rdata_o,
  output logic                io_rvalid_o,
  output logic [3*COMP_W-1:0] rgb_o,
  output logic                video_enable_o,
  output logic                graphics_mode_o,
  output logic                mono_o,
  output logic                line_gfx_o,
  output logic                blink_o,
  output logic                top_pan_o,
  output logic                colour256_o,
  output logic [7:0]          border_colour_o,
  output logic [3:0]          plane_enable_o,
  output logic [3:0]          pan_o,
  output logic [7:0]          attr_diag_o
);

  // ----------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------
  function automatic logic port_hit(
    input logic [15:0] addr,
    input logic [15:0] port
  );
    return addr == port;
  endfunction

  logic wr_attr;
  logic wr_mask;
  logic wr_rd_ptr;
  logic wr_wr_ptr;
  logic wr_data;
  logic rd_data;
  logic rd_stat1;

  assign wr_attr   = io_wr_i && port_hit(io_addr_i, `PORT_ATTR_INDEX);
  assign wr_mask   = io_wr_i && port_hit(io_addr_i, `PORT_PIX_MASK);
  assign wr_rd_ptr = io_wr_i && port_hit(io_addr_i, `PORT_RD_POINTER);
  assign wr_wr_ptr = io_wr_i && port_hit(io_addr_i, `PORT_WR_POINTER);
  assign wr_data   = io_wr_i && port_hit(io_addr_i, `PORT_PAL_DATA);
  assign rd_data   = io_rd_i && port_hit(io_addr_i, `PORT_PAL_DATA);
  assign rd_stat1  = io_rd_i &&
                     (port_hit(io_addr_i, `PORT_STAT1_MONO) ||
                      port_hit(io_addr_i, `PORT_STAT1_COLOUR));

  // ----------------------------------------------------------
  // Attribute index, flip-flop and registers
  // ----------------------------------------------------------
  attr_phase_t attr_phase, next_attr_phase;
  logic [4:0]  attr_index, next_attr_index;
  logic        video_en, next_video_en;
  logic [7:0]  mode, next_mode;
  logic [7:0]  border, next_border;
  logic [7:0]  plane, next_plane;
  logic [7:0]  hpan, next_hpan;
  logic [7:0]  pad, next_pad;
  logic [7:0]  mask, next_mask;
  logic [7:0]  diag, next_diag;

  always_comb begin
    next_attr_phase = attr_phase;
    next_attr_index = attr_index;
    next_video_en   = video_en;
    next_mode       = mode;
    next_border     = border;
    next_plane      = plane;
    next_hpan       = hpan;
    next_pad        = pad;
    next_mask       = mask;
    if (rd_stat1) begin
      next_attr_phase = ATTR_IDX;
    end else if (wr_attr) begin
      unique case (attr_phase)
        ATTR_IDX: begin
          next_attr_index = io_wdata_i[4:0];
          next_video_en   = io_wdata_i[`INDEX_VIDEO_EN];
          next_attr_phase = ATTR_DATA;
        end
        ATTR_DATA: begin
          case (attr_index)
            `IDX_MODE_CONTROL: next_mode   = io_wdata_i;
            `IDX_BORDER:       next_border = io_wdata_i;
            `IDX_PLANE_ENABLE: next_plane  = io_wdata_i;
            `IDX_HPAN:         next_hpan   = io_wdata_i;
            `IDX_PIXEL_PAD:    next_pad    = io_wdata_i;
            default:           next_mode   = mode;
          endcase
          next_attr_phase = ATTR_IDX;
        end
      endcase
    end
    if (wr_mask) begin
      next_mask = io_wdata_i;
    end
    next_diag = {next_attr_phase == ATTR_IDX, 1'b0,
                 next_video_en, next_attr_index};
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      attr_phase <= ATTR_IDX;
      attr_index <= `INDEX_RESET;
      video_en   <= 1'b0;
      mode       <= `ATTR_RESET;
      border     <= `ATTR_RESET;
      plane      <= `ATTR_RESET;
      hpan       <= `ATTR_RESET;
      pad        <= `ATTR_RESET;
      mask       <= `MASK_RESET;
      diag       <= {1'b1, 7'h00};
    end else begin
      attr_phase <= next_attr_phase;
      attr_index <= next_attr_index;
      video_en   <= next_video_en;
      mode       <= next_mode;
      border     <= next_border;
      plane      <= next_plane;
      hpan       <= next_hpan;
      pad        <= next_pad;
      mask       <= next_mask;
      diag       <= next_diag;
    end
  end

  // ----------------------------------------------------------
  // Pixel path and palette
  // ----------------------------------------------------------
  logic [7:0]       pix_addr;
  logic [7:0]       pal_byte;
  logic [IDX_W-1:0] wr_index;
  logic [1:0]       pal_status;

  vga_pixel_mux u_pixel_mux (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (rst_i),
    .colour_i     (attr_colour_i),
    .pad_select_i (mode[`MODE_PAD_SELECT]),
    .colour256_i  (mode[`MODE_COLOUR256]),
    .pad_i        (pad[3:0]),
    .mask_i       (mask),
    .pix_o        (pix_addr)
  );

  vga_palette_ram #(
    .IDX_W  (IDX_W),
    .COMP_W (COMP_W)
  ) u_palette (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (rst_i),
    .data_wr_i    (wr_data),
    .data_rd_i    (rd_data),
    .wdata_i      (io_wdata_i),
    .rd_load_i    (wr_rd_ptr),
    .wr_load_i    (wr_wr_ptr),
    .pixel_addr_i (pix_addr[IDX_W-1:0]),
    .host_byte_o  (pal_byte),
    .wr_index_o   (wr_index),
    .status_o     (pal_status),
    .rgb_o        (rgb_o)
  );

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  logic [7:0] rdata, next_rdata;
  logic       rvalid, next_rvalid;
  logic [1:0] diag_pick;

  always_comb begin
    unique case (plane[5:4])
      2'b00:   diag_pick = {pix_addr[2], pix_addr[0]};
      2'b01:   diag_pick = {pix_addr[5], pix_addr[4]};
      2'b10:   diag_pick = {pix_addr[3], pix_addr[1]};
      default: diag_pick = {pix_addr[7], pix_addr[6]};
    endcase
  end

  always_comb begin
    next_rdata  = rdata;
    next_rvalid = io_rd_i;
    if (io_rd_i) begin
      next_rdata = 8'h00;
      if (port_hit(io_addr_i, `PORT_ATTR_INDEX)) begin
        next_rdata = {2'b00, video_en, attr_index};
      end else if (port_hit(io_addr_i, `PORT_ATTR_READ)) begin
        case (attr_index)
          `IDX_MODE_CONTROL: next_rdata = mode;
          `IDX_BORDER:       next_rdata = border;
          `IDX_PLANE_ENABLE: next_rdata = plane;
          `IDX_HPAN:         next_rdata = hpan;
          `IDX_PIXEL_PAD:    next_rdata = pad;
          default:           next_rdata = 8'h00;
        endcase
      end else if (port_hit(io_addr_i, `PORT_PIX_MASK)) begin
        next_rdata = mask;
      end else if (port_hit(io_addr_i, `PORT_RD_POINTER)) begin
        next_rdata = {6'h00, pal_status};
      end else if (port_hit(io_addr_i, `PORT_WR_POINTER)) begin
        next_rdata = {{(8-IDX_W){1'b0}}, wr_index};
      end else if (port_hit(io_addr_i, `PORT_PAL_DATA)) begin
        next_rdata = pal_byte;
      end else if (rd_stat1) begin
        next_rdata[5:4]              = diag_pick;
        next_rdata[`STAT1_VSYNC]     = vsync_i;
        next_rdata[`STAT1_INACTIVE]  = display_inactive_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign io_rdata_o      = rdata;
  assign io_rvalid_o     = rvalid;
  assign video_enable_o  = video_en;
  assign graphics_mode_o = mode[`MODE_GRAPHICS];
  assign mono_o          = mode[`MODE_MONO];
  assign line_gfx_o      = mode[`MODE_LINE_GFX];
  assign blink_o         = mode[`MODE_BLINK];
  assign top_pan_o       = mode[`MODE_TOP_PAN];
  assign colour256_o     = mode[`MODE_COLOUR256];
  assign border_colour_o = border;
  assign plane_enable_o  = plane[3:0];
  assign pan_o           = hpan[3:0];
  assign attr_diag_o     = diag;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_index_wr;
    wr_attr && attr_phase == ATTR_IDX && !rd_stat1;
  endsequence

  sequence s_data_wr(logic [4:0] idx);
    wr_attr && attr_phase == ATTR_DATA && attr_index == idx;
  endsequence

  AST_MODE_LOW: assert property (
    s_data_wr(`IDX_MODE_CONTROL) |=> graphics_mode_o == $past(io_wdata_i[0])
      && mono_o == $past(io_wdata_i[1]) && blink_o == $past(io_wdata_i[3]))
    else $error("mode control low bits not stored");

  AST_MODE_HIGH: assert property (
    s_data_wr(`IDX_MODE_CONTROL) |=> top_pan_o == $past(io_wdata_i[5])
      && colour256_o == $past(io_wdata_i[6]))
    else $error("mode control high bits not stored");

  AST_PLANES: assert property (
    s_data_wr(`IDX_PLANE_ENABLE) |=> plane_enable_o == $past(io_wdata_i[3:0]))
    else $error("plane enable not stored");

  AST_PAN: assert property (
    s_data_wr(`IDX_HPAN) |=> pan_o == $past(io_wdata_i[3:0]))
    else $error("panning not stored");

  AST_INDEX: assert property (
    s_index_wr |=> video_enable_o == $past(io_wdata_i[5])
      && attr_diag_o[4:0] == $past(io_wdata_i[4:0]))
    else $error("attribute index not taken");

  AST_FLIP: assert property (
    s_index_wr ##1 (wr_attr && !rd_stat1) |=> attr_diag_o[7] == 1'b1)
    else $error("flip-flop did not return to index after data");

  AST_FLIP_RESET: assert property (
    rd_stat1 |=> attr_diag_o[7] == 1'b1 ##1 attr_diag_o[7] == 1'b1
      || $past(wr_attr))
    else $error("status read did not reset flip-flop");

  AST_STATUS: assert property (
    wr_rd_ptr ##1 (io_rd_i && port_hit(io_addr_i, `PORT_RD_POINTER))
    |=> io_rvalid_o && io_rdata_o == {6'h00, `ACCESS_READ})
    else $error("status after read pointer load wrong");

  AST_WR_PTR: assert property (
    wr_wr_ptr ##1 (io_rd_i && port_hit(io_addr_i, `PORT_WR_POINTER))
    |=> io_rdata_o == $past(io_wdata_i, 2))
    else $error("write pointer not read back");

endmodule

/* File: bench/vga_host_model.sv */
// Host model issuing byte-wide I/O port cycles
// Assumes the bench calls its tasks; drives on falling edges
`include "vga_attr_regs.svh"
module vga_host_model (
  input  logic        sys_clk_i,
  input  logic [7:0]  io_rdata_i,
  input  logic        io_rvalid_i,
  output logic [15:0] io_addr_o,
  output logic        io_wr_o,
  output logic        io_rd_o,
  output logic [7:0]  io_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    io_addr_o = 16'h0000;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
  end
  // One write strobe, then released lines show inverted values
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = 1'b1;
    @(negedge sys_clk_i);
    io_wr_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
  endtask
  // Read strobe; data taken while the valid pulse stands
  task automatic rd(input logic [15:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge sys_clk_i);
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(negedge sys_clk_i);
    io_rd_o = 1'b0;
    io_addr_o = ~a;
    d = io_rdata_i;
    v = io_rvalid_i;
  endtask
  // Write then read at the next edge, no idle cycle between
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] wd,
                       input logic [15:0] ra, output logic [7:0] d,
                       output logic v);
    @(negedge sys_clk_i);
    io_addr_o = a;
    io_wdata_o = wd;
    io_wr_o = 1'b1;
    @(negedge sys_clk_i);
    io_wr_o = 1'b0;
    io_addr_o = ra;
    io_rd_o = 1'b1;
    @(negedge sys_clk_i);
    io_rd_o = 1'b0;
    io_addr_o = ~ra;
    io_wdata_o = ~wd;
    d = io_rdata_i;
    v = io_rvalid_i;
  endtask
  // Index then attribute data back to back, strobe held
  task automatic aw(input logic [4:0] i, input logic [7:0] d);
    @(negedge sys_clk_i);
    io_addr_o = `PORT_ATTR_INDEX;
    io_wdata_o = {3'b001, i};
    io_wr_o = 1'b1;
    @(negedge sys_clk_i);
    io_wdata_o = d;
    @(negedge sys_clk_i);
    io_wr_o = 1'b0;
    io_addr_o = ~`PORT_ATTR_INDEX;
    io_wdata_o = ~d;
  endtask
  // Pointer loaded before the three colour bytes
  task automatic pw(input logic [7:0] i, input logic [17:0] c);
    wr(`PORT_WR_POINTER, i);
    wr(`PORT_PAL_DATA, {2'b00, c[17:12]});
    wr(`PORT_PAL_DATA, {2'b00, c[11:6]});
    wr(`PORT_PAL_DATA, {2'b00, c[5:0]});
  endtask
endmodule

/* File: bench/vga_attribute_palette_regs_tb_top.sv */
// Self-checking bench for the attribute and palette register bank
// Assumes the host model file and the design files are compiled first
`include "vga_attr_regs.svh"
module vga_attribute_palette_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic vsync_i = 1'b1;
  logic inact_i = 1'b0;
  logic [7:0] colour = 8'h05;
  logic [15:0] addr;
  logic wr, rd, rv, v, ve, gm, mo, lg, bl, tp, c2;
  logic [7:0] wd, rdat, d, bc, diag;
  logic [17:0] rgb;
  logic [3:0] pe, pan;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  vga_host_model host (.sys_clk_i(sys_clk_i), .io_rdata_i(rdat),
    .io_rvalid_i(rv), .io_addr_o(addr), .io_wr_o(wr), .io_rd_o(rd),
    .io_wdata_o(wd));
  vga_attribute_palette_regs uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wd),
    .vsync_i(vsync_i), .display_inactive_i(inact_i),
    .attr_colour_i(colour), .io_rdata_o(rdat), .io_rvalid_o(rv),
    .rgb_o(rgb), .video_enable_o(ve), .graphics_mode_o(gm), .mono_o(mo),
    .line_gfx_o(lg), .blink_o(bl), .top_pan_o(tp), .colour256_o(c2),
    .border_colour_o(bc), .plane_enable_o(pe), .pan_o(pan),
    .attr_diag_o(diag));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(string n, logic [17:0] s, logic [17:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic rdc(string n, logic [15:0] a, logic [7:0] e);
    host.rd(a, d, v);
    chk({n, " valid"}, v, 1'b1);
    chk(n, d, e);
  endtask
  task automatic t_reset();
    chk("diag", diag, 8'h80);
    rdc("mask", `PORT_PIX_MASK, 8'hFF);
  endtask
  task automatic t_attr();
    rdc("stat1", `PORT_STAT1_COLOUR, 8'h38);
    host.aw(5'h10, 8'h6B);
    host.aw(5'h11, 8'hA5);
    host.aw(5'h12, 8'h3A);
    host.aw(5'h13, 8'h17);
    host.aw(5'h14, 8'h0E);
    chk("mode", {gm, mo, lg, bl}, 4'b1101);
    chk("mode hi", {tp, c2}, 2'b11);
    chk("border", bc, 8'hA5);
    chk("planes", pe, 4'hA);
    chk("pan", pan, 4'h7);
    rdc("stat1 sel", `PORT_STAT1_MONO, 8'h08);
    host.wr(`PORT_ATTR_INDEX, 8'h31);
    chk("video", ve, 1'b1);
    chk("diag", diag, 8'h31);
    rdc("attr rd", `PORT_ATTR_READ, 8'hA5);
    host.wr(`PORT_ATTR_INDEX, 8'h5A);
    chk("diag2", diag, 8'hB1);
  endtask
  task automatic t_palette();
    host.pw(8'h05, 18'h3F56A);
    host.pw(8'hE5, 18'h01083);
    rdc("stat w", `PORT_RD_POINTER, 8'h00);
    rdc("wptr", `PORT_WR_POINTER, 8'hE6);
    host.wr_rd(`PORT_WR_POINTER, 8'h40, `PORT_WR_POINTER, d, v);
    chk("wptr ld valid", v, 1'b1);
    chk("wptr ld", d, 8'h40);
    host.wr_rd(`PORT_RD_POINTER, 8'h05, `PORT_RD_POINTER, d, v);
    chk("stat ld valid", v, 1'b1);
    chk("stat ld", d, 8'h03);
    rdc("red", `PORT_PAL_DATA, 8'h3F);
    rdc("green", `PORT_PAL_DATA, 8'h15);
    rdc("blue", `PORT_PAL_DATA, 8'h2A);
    rdc("stat r", `PORT_RD_POINTER, 8'h03);
  endtask
  task automatic t_pixel();
    repeat (3) @(negedge sys_clk_i);
    chk("rgb raw", rgb, 18'h3F56A);
    host.aw(5'h10, 8'hAB);
    repeat (3) @(negedge sys_clk_i);
    chk("rgb pad", rgb, 18'h01083);
    host.wr(`PORT_PIX_MASK, 8'h0F);
    repeat (3) @(negedge sys_clk_i);
    chk("rgb mask", rgb, 18'h3F56A);
  endtask
  initial begin
    repeat (10) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_attr();
    t_palette();
    t_pixel();
    end_of_test();
  end
endmodule
